// file: hw/clk_ctrl_defines.svh
// named constants for the system clock control block
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

`define CD_MULT 2'b00
`define CD_RSVD 2'b01
`define CD_DIV4 2'b10
`define CD_PMM 2'b11
`define CD_RESET `CD_DIV4

`define TA_ADDR 8'hc7
`define TA_KEY1 8'haa
`define TA_KEY2 8'h55

`define CLK_HZ 20000000
`define OFD_MIN_HZ 40000
`define OFD_LIMIT_CYCLES (`CLK_HZ / `OFD_MIN_HZ)

`define LOCK_OSC_TICKS 65536
`define RING_OSC_TICKS 65536
`define DIV_SLOW 256
`define MACHINE_DIV 4
`define MULT_SHIFT_2X 1
`define MULT_SHIFT_4X 2

`endif

// file: hw/clk_ctrl_pkg.sv
// types shared by the system clock control block
package clk_ctrl_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_CLEARED = 3'b001,
    SEQ_FACTOR = 3'b011,
    SEQ_ENABLED = 3'b010
  } mult_seq_e;

  typedef enum logic [1:0] {
    TA_CLOSED = 2'b00,
    TA_KEY1_SEEN = 2'b01,
    TA_OPEN = 2'b11
  } timed_access_e;

endpackage

// file: hw/system_tick_gen.sv
// system clock tick generator: direct, slow divide, or multiplied oscillator
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"

module system_tick_gen #(
  parameter int PERIOD_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic [1:0] activeSelect,
  input wire logic multiplierFactorSelect,
  output logic sysTick
);

  logic [PERIOD_W-1:0] sinceOsc_q;
  logic [PERIOD_W-1:0] gap_q;
  logic [PERIOD_W-1:0] phase_q;
  logic [1:0] subLeft_q;
  logic [7:0] slowCnt_q;
  logic subTick;

  // oscillator period in clocks, measured every edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sinceOsc_q <= '0;
      gap_q <= '0;
    end else if (oscTick) begin
      sinceOsc_q <= '0;
      if (multiplierFactorSelect)
        gap_q <= (sinceOsc_q + PERIOD_W'(1)) >> `MULT_SHIFT_4X;
      else
        gap_q <= (sinceOsc_q + PERIOD_W'(1)) >> `MULT_SHIFT_2X;
    end else if (sinceOsc_q != '1) begin
      sinceOsc_q <= sinceOsc_q + PERIOD_W'(1);
    end
  end

  // extra ticks spread evenly inside one oscillator period
  assign subTick = (subLeft_q != 2'd0) && (phase_q == '0) && !oscTick;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
      subLeft_q <= 2'd0;
    end else if (oscTick) begin
      phase_q <= (gap_q == '0) ? '0 : gap_q - PERIOD_W'(1);
      subLeft_q <= multiplierFactorSelect ? 2'd3 : 2'd1;
    end else if (subTick) begin
      phase_q <= (gap_q == '0) ? '0 : gap_q - PERIOD_W'(1);
      subLeft_q <= subLeft_q - 2'd1;
    end else if (phase_q != '0) begin
      phase_q <= phase_q - PERIOD_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      slowCnt_q <= '0;
    else if (oscTick)
      slowCnt_q <= slowCnt_q + 8'd1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sysTick <= 1'b0;
    end else begin
      case (activeSelect)
        `CD_MULT: sysTick <= oscTick || subTick;
        `CD_DIV4: sysTick <= oscTick;
        `CD_PMM: sysTick <= oscTick && (slowCnt_q == 8'(`DIV_SLOW - 1));
        default: sysTick <= oscTick;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: hw/osc_fail_detector.sv
// oscillator loss watchdog counting clocks between oscillator edges
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"

module osc_fail_detector #(
  parameter int LIMIT_W = 12
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic enable,
  input wire logic stopMode,
  output logic oscFail
);

  localparam logic [LIMIT_W-1:0] Limit = LIMIT_W'(`OFD_LIMIT_CYCLES);
  logic [LIMIT_W-1:0] since_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      since_q <= '0;
    else if (oscTick || stopMode)
      since_q <= '0;
    else if (since_q != Limit)
      since_q <= since_q + LIMIT_W'(1);
  end

  // stop mode halts the oscillator on purpose, so it never counts as loss
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      oscFail <= 1'b0;
    else
      oscFail <= enable && !stopMode && !oscTick && (since_q == Limit);
  end

endmodule
`default_nettype wire

// file: hw/system_clock_control.sv
// system clock source selection, multiplier entry and oscillator-fail reset
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"

module system_clock_control #(
  parameter int LOCK_TICKS = `LOCK_OSC_TICKS,
  parameter int RING_TICKS = `RING_OSC_TICKS,
  parameter int COUNT_W = 17
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic stopMode,
  input wire logic ringStart,
  input wire logic powerFailRst,
  input wire logic taWrEn,
  input wire logic [7:0] taWrAddr,
  input wire logic [7:0] taWrData,
  input wire logic selectWrEn,
  input wire logic [1:0] selectWrData,
  input wire logic factorWrEn,
  input wire logic factorWrData,
  input wire logic enableWrEn,
  input wire logic enableWrData,
  input wire logic failEnableWrEn,
  input wire logic failEnableWrData,
  input wire logic failFlagWrEn,
  input wire logic failFlagWrData,
  output logic [1:0] clockDivideSelect,
  output logic [1:0] activeSelect,
  output logic multiplierFactorSelect,
  output logic multiplierEnable,
  output logic multiplierReadyFlag,
  output logic ringOscActiveFlag,
  output logic oscFailDetectEnable,
  output logic oscFailFlag,
  output logic sysTick,
  output logic machineTick,
  output logic cpuReset
);

  localparam logic [COUNT_W-1:0] LockLast = COUNT_W'(LOCK_TICKS - 1);
  localparam logic [COUNT_W-1:0] RingLast = COUNT_W'(RING_TICKS - 1);

  clk_ctrl_pkg::mult_seq_e seq_q;
  clk_ctrl_pkg::timed_access_e ta_q;
  logic [1:0] select_q;
  logic [1:0] active_q;
  logic factor_q;
  logic enable_q;
  logic ready_q;
  logic [COUNT_W-1:0] lockCnt_q;
  logic ring_q;
  logic [COUNT_W-1:0] ringCnt_q;
  logic failEnable_q;
  logic failFlag_q;
  logic [1:0] machineCnt_q;
  logic machine_q;
  logic oscFail;
  logic anyWrite;
  logic selectValid;
  logic entryAllowed;

  // ---------------------------------------------------------------
  // selector write filtering
  // ---------------------------------------------------------------

  assign entryAllowed = (seq_q == clk_ctrl_pkg::SEQ_ENABLED) && ready_q;

  always_comb begin
    selectValid = 1'b0;
    if (selectWrData == select_q) begin
      selectValid = 1'b1;
    end else begin
      case (selectWrData)
        `CD_DIV4: selectValid = 1'b1;
        `CD_PMM: selectValid = (select_q == `CD_DIV4);
        `CD_MULT: selectValid = (select_q == `CD_DIV4) && entryAllowed;
        `CD_RSVD: selectValid = 1'b0;
        default: selectValid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      select_q <= `CD_RESET;
    else if (selectWrEn && selectValid)
      select_q <= selectWrData;
  end

  // the running source follows the selector only at a machine boundary,
  // so a switch never cuts a machine cycle short
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      active_q <= `CD_RESET;
    else if (machine_q)
      active_q <= select_q;
  end

  // ---------------------------------------------------------------
  // multiplier controls and entry sequence
  // ---------------------------------------------------------------

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      factor_q <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      if (factorWrEn)
        factor_q <= factorWrData;
      if (enableWrEn)
        enable_q <= enableWrData;
    end
  end

  // any step out of order drops back to the start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seq_q <= clk_ctrl_pkg::SEQ_IDLE;
    end else if (select_q != `CD_DIV4 || ring_q) begin
      seq_q <= clk_ctrl_pkg::SEQ_IDLE;
    end else if (enableWrEn && !enableWrData) begin
      seq_q <= clk_ctrl_pkg::SEQ_CLEARED;
    end else if (factorWrEn) begin
      seq_q <= (seq_q == clk_ctrl_pkg::SEQ_CLEARED) ?
               clk_ctrl_pkg::SEQ_FACTOR : clk_ctrl_pkg::SEQ_IDLE;
    end else if (enableWrEn && enableWrData) begin
      seq_q <= (seq_q == clk_ctrl_pkg::SEQ_FACTOR) ?
               clk_ctrl_pkg::SEQ_ENABLED : clk_ctrl_pkg::SEQ_IDLE;
    end else if (selectWrEn && selectWrData != `CD_DIV4) begin
      seq_q <= clk_ctrl_pkg::SEQ_IDLE;
    end else begin
      case (seq_q)
        clk_ctrl_pkg::SEQ_IDLE: seq_q <= clk_ctrl_pkg::SEQ_IDLE;
        clk_ctrl_pkg::SEQ_CLEARED: seq_q <= clk_ctrl_pkg::SEQ_CLEARED;
        clk_ctrl_pkg::SEQ_FACTOR: seq_q <= clk_ctrl_pkg::SEQ_FACTOR;
        clk_ctrl_pkg::SEQ_ENABLED: seq_q <= clk_ctrl_pkg::SEQ_ENABLED;
        default: seq_q <= clk_ctrl_pkg::SEQ_IDLE;
      endcase
    end
  end

  // lock interval counted in oscillator edges; restarts on every clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lockCnt_q <= '0;
      ready_q <= 1'b0;
    end else if (!enable_q) begin
      lockCnt_q <= '0;
      ready_q <= 1'b0;
    end else if (oscTick && !ready_q) begin
      if (lockCnt_q == LockLast)
        ready_q <= 1'b1;
      else
        lockCnt_q <= lockCnt_q + COUNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // ring oscillator flag
  // ---------------------------------------------------------------

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ring_q <= 1'b0;
      ringCnt_q <= '0;
    end else if (ringStart) begin
      ring_q <= 1'b1;
      ringCnt_q <= '0;
    end else if (ring_q && oscTick) begin
      if (ringCnt_q == RingLast)
        ring_q <= 1'b0;
      else
        ringCnt_q <= ringCnt_q + COUNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // timed access window
  // ---------------------------------------------------------------

  // any write that is not the next key closes the window
  assign anyWrite = taWrEn || selectWrEn || factorWrEn || enableWrEn ||
                    failEnableWrEn || failFlagWrEn;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ta_q <= clk_ctrl_pkg::TA_CLOSED;
    end else if (anyWrite) begin
      if (taWrEn && taWrAddr == `TA_ADDR && taWrData == `TA_KEY1)
        ta_q <= clk_ctrl_pkg::TA_KEY1_SEEN;
      else if (taWrEn && taWrAddr == `TA_ADDR && taWrData == `TA_KEY2 &&
               ta_q == clk_ctrl_pkg::TA_KEY1_SEEN)
        ta_q <= clk_ctrl_pkg::TA_OPEN;
      else
        ta_q <= clk_ctrl_pkg::TA_CLOSED;
    end
  end

  // ---------------------------------------------------------------
  // oscillator-fail detection
  // ---------------------------------------------------------------

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      failEnable_q <= 1'b0;
    else if (failEnableWrEn && ta_q == clk_ctrl_pkg::TA_OPEN)
      failEnable_q <= failEnableWrData;
  end

  osc_fail_detector #(
    .LIMIT_W(12)
  ) u_detector (
    .clock(clock),
    .nrst(nrst),
    .oscTick(oscTick),
    .enable(failEnable_q),
    .stopMode(stopMode),
    .oscFail(oscFail)
  );

  // set wins over a clear in the same cycle; cpuReset does not clear it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      failFlag_q <= 1'b0;
    else if (oscFail)
      failFlag_q <= 1'b1;
    else if (powerFailRst)
      failFlag_q <= 1'b0;
    else if (failFlagWrEn)
      failFlag_q <= failFlagWrData;
  end

  // reset stays asserted as long as the oscillator is missing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      cpuReset <= 1'b0;
    else
      cpuReset <= oscFail;
  end

  // ---------------------------------------------------------------
  // system and machine cycle ticks
  // ---------------------------------------------------------------

  system_tick_gen #(
    .PERIOD_W(16)
  ) u_ticks (
    .clock(clock),
    .nrst(nrst),
    .oscTick(oscTick),
    .activeSelect(active_q),
    .multiplierFactorSelect(factor_q),
    .sysTick(sysTick)
  );

  // machine tick lands on every fourth system tick, so timers and the cpu
  // always see the same base and the low-power mode gives osc/1024
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      machineCnt_q <= 2'd0;
      machine_q <= 1'b0;
    end else begin
      machine_q <= sysTick && (machineCnt_q == 2'(`MACHINE_DIV - 1));
      if (sysTick)
        machineCnt_q <= machineCnt_q + 2'd1;
    end
  end

  assign machineTick = machine_q;
  assign clockDivideSelect = select_q;
  assign activeSelect = active_q;
  assign multiplierFactorSelect = factor_q;
  assign multiplierEnable = enable_q;
  assign multiplierReadyFlag = ready_q;
  assign ringOscActiveFlag = ring_q;
  assign oscFailDetectEnable = failEnable_q;
  assign oscFailFlag = failFlag_q;

endmodule
`default_nettype wire

// file: verification/osc_model.sv
// oscillator stand-in: one tick pulse every PERIOD clocks while running
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
  parameter int PERIOD = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  output logic oscTick
);
  logic [7:0] phaseQ;
  // 8 clocks a period keeps 4x system ticks two clocks apart
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phaseQ <= 8'h00;
    end else begin
      phaseQ <= (phaseQ == 8'(PERIOD - 1)) ? 8'h00 : phaseQ + 8'h01;
    end
  end
  assign oscTick = run && phaseQ == 8'h00;
endmodule
`default_nettype wire

// file: verification/clk_ctrl_props.sv
// concurrent checks on the system clock control ports
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic oscTick,
  input wire logic stopMode,
  input wire logic powerFailRst,
  input wire logic taWrEn,
  input wire logic [7:0] taWrAddr,
  input wire logic [7:0] taWrData,
  input wire logic selectWrEn,
  input wire logic [1:0] selectWrData,
  input wire logic failEnableWrEn,
  input wire logic failFlagWrEn,
  input wire logic failFlagWrData,
  input wire logic [1:0] clockDivideSelect,
  input wire logic [1:0] activeSelect,
  input wire logic multiplierEnable,
  input wire logic multiplierReadyFlag,
  input wire logic oscFailDetectEnable,
  input wire logic oscFailFlag,
  input wire logic cpuReset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [9:0] gapQ;
  // clocks since the last oscillator edge while the watchdog is armed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gapQ <= 10'h000;
    end else if (oscTick || stopMode || !oscFailDetectEnable) begin
      gapQ <= 10'h000;
    end else if (gapQ != 10'h3ff) begin
      gapQ <= gapQ + 10'h001;
    end
  end
  sequence selWrite(logic [1:0] v);
    selectWrEn && selectWrData == v;
  endsequence
  a_sel_reserved: assert property (selWrite(2'b01) |=> $stable(clockDivideSelect))
    else $error("reserved selector write took effect");
  a_sel_via_div4: assert property (clockDivideSelect != 2'b10 ##0 selWrite(2'b00) or
    clockDivideSelect != 2'b10 ##0 selWrite(2'b11) |=> $stable(clockDivideSelect))
    else $error("selector skipped divide-by-4");
  a_sel_to_pmm: assert property (clockDivideSelect == 2'b10 ##0 selWrite(2'b11) |=>
    clockDivideSelect == 2'b11)
    else $error("low-power selector write lost");
  a_mult_gate: assert property (!multiplierReadyFlag ##0 selWrite(2'b00) |=>
    $stable(clockDivideSelect))
    else $error("multiplier selected before ready");
  a_ready_drop: assert property (!multiplierEnable |=> !multiplierReadyFlag)
    else $error("ready flag set with multiplier disabled");
  a_active_src: assert property ($changed(activeSelect) |->
    activeSelect == $past(clockDivideSelect))
    else $error("active source differs from selector");
  a_fail_hold: assert property (gapQ > 10'd505 |-> cpuReset)
    else $error("lost oscillator without reset");
  a_fail_flag: assert property ($rose(cpuReset) |-> ##[0:2] oscFailFlag)
    else $error("fail reset without fail flag");
  a_stop_quiet: assert property (stopMode && $past(stopMode, 3) |-> !$rose(oscFailFlag))
    else $error("fail flagged in stop mode");
  a_flag_sticky: assert property (oscFailFlag && !powerFailRst &&
    !(failFlagWrEn && !failFlagWrData) |=> oscFailFlag)
    else $error("fail flag cleared without cause");
  a_ta_guard: assert property (failEnableWrEn && $past(taWrEn) &&
    !($past(taWrAddr) == 8'hc7 && $past(taWrData) == 8'h55) |=> $stable(oscFailDetectEnable))
    else $error("detect enable written without key");
endmodule
bind system_clock_control clk_ctrl_props u_clk_ctrl_props (.clock, .nrst, .oscTick, .stopMode,
  .powerFailRst, .taWrEn, .taWrAddr, .taWrData, .selectWrEn, .selectWrData, .failEnableWrEn,
  .failFlagWrEn, .failFlagWrData, .clockDivideSelect, .activeSelect, .multiplierEnable,
  .multiplierReadyFlag, .oscFailDetectEnable, .oscFailFlag, .cpuReset);
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the system clock control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b1;
  logic stopMode = 1'b0;
  logic ringStart = 1'b0;
  logic powerFailRst = 1'b0;
  logic [2:0] wrKind = 3'h7;
  logic [7:0] wrA = 8'h00;
  logic [7:0] wrD = 8'h00;
  logic oscTick, mFactor, mEnable, mReady, ringFlag, failEn, failFlag, sysTick, mTick, cpuReset;
  logic [1:0] divSel;
  logic [1:0] actSel;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int s;
  int m;
  always #25 clock = ~clock;
  osc_model u_osc_model (.clock(clock), .nrst(nrst), .run(run), .oscTick(oscTick));
  system_clock_control #(.LOCK_TICKS(16), .RING_TICKS(16)) u_system_clock_control (
    .clock(clock), .nrst(nrst), .oscTick(oscTick), .stopMode(stopMode), .ringStart(ringStart),
    .powerFailRst(powerFailRst), .taWrEn(wrKind == 3'h0), .taWrAddr(wrA), .taWrData(wrD),
    .selectWrEn(wrKind == 3'h1), .selectWrData(wrD[1:0]), .factorWrEn(wrKind == 3'h2),
    .factorWrData(wrD[0]), .enableWrEn(wrKind == 3'h3), .enableWrData(wrD[0]),
    .failEnableWrEn(wrKind == 3'h4), .failEnableWrData(wrD[0]), .failFlagWrEn(wrKind == 3'h5),
    .failFlagWrData(wrD[0]), .clockDivideSelect(divSel), .activeSelect(actSel),
    .multiplierFactorSelect(mFactor), .multiplierEnable(mEnable), .multiplierReadyFlag(mReady),
    .ringOscActiveFlag(ringFlag), .oscFailDetectEnable(failEn), .oscFailFlag(failFlag),
    .sysTick(sysTick), .machineTick(mTick), .cpuReset(cpuReset));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write per clock; kind 7 means no write
  task automatic wr(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #2;
    wrKind = k;
    wrA = a;
    wrD = d;
  endtask
  task automatic sel(input logic [1:0] v);
    wr(3'h1, 8'h00, {6'h00, v});
    wr(3'h7, 8'h00, 8'h00);
  endtask
  // window aligned to osc ticks so the tick counts are exact
  task automatic ticks(input int n);
    int o;
    o = 0;
    s = 0;
    m = 0;
    do @(posedge clock); while (oscTick !== 1'b1);
    while (o < n) begin
      @(posedge clock);
      o += int'(oscTick === 1'b1);
      s += int'(sysTick === 1'b1);
      m += int'(mTick === 1'b1);
    end
    #2;
  endtask
  task automatic wait_for(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    wait_for(3);
    nrst = 1'b1;
    chk("selector", divSel, 8'h02);
    chk("flags", {mReady, ringFlag, failEn, failFlag, cpuReset}, 8'h00);
    sel(2'b01);
    chk("reserved", divSel, 8'h02);
    sel(2'b00);
    chk("direct mult", divSel, 8'h02);
    ticks(16);
    chk("div4 sys", 8'(s), 8'h10);
    chk("div4 machine", 8'(m), 8'h04);
    sel(2'b11);
    chk("to pmm", divSel, 8'h03);
    sel(2'b00);
    chk("pmm to mult", divSel, 8'h03);
    ticks(16);
    chk("active pmm", actSel, 8'h03);
    ticks(1024);
    chk("pmm sys", 8'(s), 8'h04);
    chk("pmm machine", 8'(m), 8'h01);
    sel(2'b10);
    repeat (9000) if (actSel !== 2'b10) @(posedge clock);
    chk("back div4", {divSel, actSel}, 8'h0a);
    $display("test selector done");
    wr(3'h3, 8'h00, 8'h01);
    wr(3'h7, 8'h00, 8'h00);
    ticks(20);
    sel(2'b00);
    chk("skip clear", divSel, 8'h02);
    for (int f = 0; f < 2; f++) begin
      wr(3'h3, 8'h00, 8'h00);
      wr(3'h2, 8'h00, 8'(f));
      wr(3'h3, 8'h00, 8'h01);
      wr(3'h7, 8'h00, 8'h00);
      ticks(8);
      chk("ready early", mReady, 8'h00);
      repeat (400) if (mReady !== 1'b1) @(posedge clock);
      chk("ready", {mReady, mFactor}, 8'(2 + f));
      chk("enable", mEnable, 8'h01);
      sel(2'b00);
      chk("mult sel", divSel, 8'h00);
      ticks(8);
      ticks(8);
      chk("mult sys", 8'(s), f ? 8'h20 : 8'h10);
      chk("mult machine", 8'(m), f ? 8'h08 : 8'h04);
      sel(2'b10);
      chk("leave mult", divSel, 8'h02);
      ticks(8);
    end
    $display("test multiplier done");
    wr(3'h0, 8'hc7, 8'haa);
    wr(3'h0, 8'hc7, 8'h56);
    wr(3'h4, 8'h00, 8'h01);
    wr(3'h7, 8'h00, 8'h00);
    chk("guarded", failEn, 8'h00);
    wr(3'h0, 8'hc7, 8'haa);
    wr(3'h0, 8'hc7, 8'h55);
    wr(3'h4, 8'h00, 8'h01);
    wr(3'h7, 8'h00, 8'h00);
    chk("unlocked", failEn, 8'h01);
    run = 1'b0;
    stopMode = 1'b1;
    wait_for(700);
    chk("stop quiet", {failFlag, cpuReset}, 8'h00);
    stopMode = 1'b0;
    wait_for(700);
    chk("fail", {failFlag, cpuReset}, 8'h03);
    run = 1'b1;
    wait_for(20);
    chk("released", {failFlag, cpuReset}, 8'h02);
    powerFailRst = 1'b1;
    wait_for(1);
    powerFailRst = 1'b0;
    wait_for(1);
    chk("power clear", failFlag, 8'h00);
    $display("test fail detect done");
    ringStart = 1'b1;
    wait_for(1);
    ringStart = 1'b0;
    wait_for(1);
    chk("ring set", ringFlag, 8'h01);
    wr(3'h3, 8'h00, 8'h00);
    wr(3'h2, 8'h00, 8'h00);
    wr(3'h3, 8'h00, 8'h01);
    wr(3'h7, 8'h00, 8'h00);
    ticks(24);
    chk("ring clear", {ringFlag, mReady}, 8'h01);
    sel(2'b00);
    chk("ring blocks", divSel, 8'h02);
    $display("test ring done");
    give_verdict();
  end
endmodule
`default_nettype wire
